// >>> logic/dpgpio_pkg.sv
// Constants, register map and carrier types of the dual port group GPIO
// Overview of operation
// - Each group has eight pins with out, in, enables and pull controls.
// - First group pins have edge select, interrupt enable, debounce enable.
// - Flags clear only on writing one; flag upper byte reads zero.
// - Mode bit clear gives pin to GPIO; set selects 2-bit function.
// - Function 1 routes to universal router; functions 2 and 3 unused.
// - Function 0: pins 0-3 feed timer external clock inputs.
// - Second group mode reads 0x0000, function reads 0xaaaa, writes ignored.
// - Second group keeps GPIO controls, edge interrupts, flags, debounce.
// - Every writable field clears to zero on system reset.
package dpgpio_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int PINS = 8;
   // Register byte offsets, one aligned word each
   localparam logic [5:0] G1_DATA = 6'h00;
   localparam logic [5:0] G1_IOEN = 6'h04;
   localparam logic [5:0] G1_RCTL = 6'h08;
   localparam logic [5:0] G1_INTF = 6'h0c;
   localparam logic [5:0] G1_INTCTL = 6'h10;
   localparam logic [5:0] G1_CHAT = 6'h14;
   localparam logic [5:0] G1_MODE = 6'h18;
   localparam logic [5:0] G1_FUNC = 6'h1c;
   localparam logic [5:0] G2_DATA = 6'h20;
   localparam logic [5:0] G2_IOEN = 6'h24;
   localparam logic [5:0] G2_RCTL = 6'h28;
   localparam logic [5:0] G2_INTF = 6'h2c;
   localparam logic [5:0] G2_INTCTL = 6'h30;
   localparam logic [5:0] G2_CHAT = 6'h34;
   localparam logic [5:0] G2_MODE = 6'h38;
   localparam logic [5:0] G2_FUNC = 6'h3c;
   // Reset and fixed values
   localparam logic [15:0] RST_VAL = 16'h0000;
   localparam logic [15:0] G2_MODE_VAL = 16'h0000;
   localparam logic [15:0] G2_FUNC_VAL = 16'haaaa;
   // Function codes
   localparam logic [1:0] FN_TIMER = 2'h0;
   localparam logic [1:0] FN_ROUTER = 2'h1;
   // Debounce: input must be stable this many cycles
   localparam int DEB_CYC = 4;

   // Per-group control set
   typedef struct packed {
      logic [7:0] out_bits;
      logic [7:0] in_en;
      logic [7:0] out_en;
      logic [7:0] pull_dir;
      logic [7:0] pull_en;
      logic [7:0] edge_sel;
      logic [7:0] irq_en;
      logic [7:0] deb_en;
   } dpgpio_grp_s;

   // Pin-side outputs of one group
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] ie;
      logic [7:0] pull_en;
      logic [7:0] pull_up;
   } dpgpio_pad_s;
endpackage : dpgpio_pkg

// >>> logic/dpgpio_top.sv
// Two port groups: registers, pin control, edge interrupts, peripheral routing
`timescale 1ns/100ps
module dpgpio_top #(
   parameter int DEB_CYC = dpgpio_pkg::DEB_CYC
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [5:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [7:0] first_group_pin_in,
   input wire logic [7:0] second_group_pin_in,
   output dpgpio_pkg::dpgpio_pad_s first_group_pad,
   output dpgpio_pkg::dpgpio_pad_s second_group_pad,
   output logic [7:0] first_group_periph_sel,
   output logic [7:0] router_pin_sel,
   input wire logic [7:0] router_out,
   input wire logic [7:0] router_oe,
   output logic timer0_ext_clock_b,
   output logic timer1_ext_clock_b,
   output logic timer2_ext_clock_a,
   output logic timer2_ext_clock_b,
   output logic irq
);
   dpgpio_pkg::dpgpio_grp_s g_q [2];
   logic [7:0] flag_q [2];
   logic [7:0] mode_q;
   logic [15:0] func_q;
   logic [7:0] in_q [2];
   logic [7:0] filt_q [2];
   logic [7:0] prev_q [2];
   logic [7:0] raw [2];
   logic [15:0] rdata_d;
   logic [15:0] rdata_q;
   logic [15:0] ctl_rd [2][6];

   assign raw[0] = first_group_pin_in;
   assign raw[1] = second_group_pin_in;

   // Per-group logic repeated with one generate loop
   for (genvar g = 0; g < 2; g++) begin : grp
      localparam logic [5:0] BASE = g ? dpgpio_pkg::G2_DATA : 6'h00;
      logic wr_data, wr_ioen, wr_rctl, wr_intf, wr_intctl, wr_chat;
      logic [7:0] rise, fall, hit;
      assign wr_data = reg_wr && reg_addr == BASE + dpgpio_pkg::G1_DATA;
      assign wr_ioen = reg_wr && reg_addr == BASE + dpgpio_pkg::G1_IOEN;
      assign wr_rctl = reg_wr && reg_addr == BASE + dpgpio_pkg::G1_RCTL;
      assign wr_intf = reg_wr && reg_addr == BASE + dpgpio_pkg::G1_INTF;
      assign wr_intctl = reg_wr && reg_addr == BASE + dpgpio_pkg::G1_INTCTL;
      assign wr_chat = reg_wr && reg_addr == BASE + dpgpio_pkg::G1_CHAT;

      always_ff @(posedge sys_clk) begin
         if (srst) begin
            g_q[g] <= '0;
         end else begin
            if (wr_data) g_q[g].out_bits <= reg_wdata[15:8];
            if (wr_ioen) begin
               g_q[g].in_en <= reg_wdata[15:8];
               g_q[g].out_en <= reg_wdata[7:0];
            end
            if (wr_rctl) begin
               g_q[g].pull_dir <= reg_wdata[15:8];
               g_q[g].pull_en <= reg_wdata[7:0];
            end
            if (wr_intctl) begin
               g_q[g].edge_sel <= reg_wdata[15:8];
               g_q[g].irq_en <= reg_wdata[7:0];
            end
            if (wr_chat) g_q[g].deb_en <= reg_wdata[7:0];
         end
      end

      // Input sampled only while its input enable is set; else reads 0
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            in_q[g] <= 8'h00;
         end else begin
            in_q[g] <= raw[g] & g_q[g].in_en;
         end
      end

      // Debounce per pin: follow input after DEB_CYC stable cycles
      for (genvar p = 0; p < 8; p++) begin : pin
         logic [3:0] cnt_q;
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               cnt_q <= 4'h0;
               filt_q[g][p] <= 1'b0;
            end else if (!g_q[g].deb_en[p] || in_q[g][p] == filt_q[g][p]) begin
               cnt_q <= 4'h0;
               filt_q[g][p] <= in_q[g][p];
            end else if (cnt_q == 4'(DEB_CYC - 1)) begin
               cnt_q <= 4'h0;
               filt_q[g][p] <= in_q[g][p];
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end

      // Edge memory of the filtered input
      always_ff @(posedge sys_clk) begin
         if (srst) prev_q[g] <= 8'h00;
         else prev_q[g] <= filt_q[g];
      end

      // edge select: 0 rising, 1 falling
      assign rise = filt_q[g] & ~prev_q[g];
      assign fall = ~filt_q[g] & prev_q[g];
      assign hit = (rise & ~g_q[g].edge_sel) | (fall & g_q[g].edge_sel);

      always_ff @(posedge sys_clk) begin
         if (srst) flag_q[g] <= 8'h00;
         else if (wr_intf) flag_q[g] <= (flag_q[g] & ~reg_wdata[7:0]) | hit;
         else flag_q[g] <= flag_q[g] | hit;
      end

      assign ctl_rd[g][0] = {g_q[g].out_bits, in_q[g]};
      assign ctl_rd[g][1] = {g_q[g].in_en, g_q[g].out_en};
      assign ctl_rd[g][2] = {g_q[g].pull_dir, g_q[g].pull_en};
      assign ctl_rd[g][3] = {8'h00, flag_q[g]};
      assign ctl_rd[g][4] = {g_q[g].edge_sel, g_q[g].irq_en};
      assign ctl_rd[g][5] = {8'h00, g_q[g].deb_en};
   end

   // mode and function selectors of first group
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_q <= 8'h00;
         func_q <= dpgpio_pkg::RST_VAL;
      end else begin
         if (reg_wr && reg_addr == dpgpio_pkg::G1_MODE) mode_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == dpgpio_pkg::G1_FUNC) func_q <= reg_wdata;
      end
   end

   // per-pin routing of first group
   // Whole pad struct is built here so it has one driving process
   always_comb begin
      first_group_periph_sel = 8'h00;
      router_pin_sel = 8'h00;
      first_group_pad.out = g_q[0].out_bits;
      first_group_pad.oe = g_q[0].out_en;
      first_group_pad.ie = g_q[0].in_en;
      first_group_pad.pull_en = g_q[0].pull_en;
      first_group_pad.pull_up = g_q[0].pull_dir;
      for (int p = 0; p < 8; p++) begin
         if (mode_q[p]) begin
            first_group_periph_sel[p] = 1'b1;
            first_group_pad.oe[p] = 1'b0;
            first_group_pad.out[p] = 1'b0;
            if (func_q[2*p +: 2] == dpgpio_pkg::FN_ROUTER) begin
               router_pin_sel[p] = 1'b1;
               first_group_pad.out[p] = router_out[p];
               first_group_pad.oe[p] = router_oe[p];
            end
         end
      end
   end
   assign second_group_pad.out = g_q[1].out_bits;
   assign second_group_pad.oe = g_q[1].out_en;
   assign second_group_pad.ie = g_q[1].in_en;
   assign second_group_pad.pull_en = g_q[1].pull_en;
   assign second_group_pad.pull_up = g_q[1].pull_dir;

   // timer clock inputs on function 0, raw pin level
   always_comb begin
      logic [3:0] t;
      t = 4'h0;
      for (int p = 0; p < 4; p++) begin
         t[p] = mode_q[p] && func_q[2*p +: 2] == dpgpio_pkg::FN_TIMER
                && first_group_pin_in[p];
      end
      timer0_ext_clock_b = t[0];
      timer1_ext_clock_b = t[1];
      timer2_ext_clock_a = t[2];
      timer2_ext_clock_b = t[3];
   end

   // request while flag and enable set
   assign irq = |(flag_q[0] & g_q[0].irq_en) | |(flag_q[1] & g_q[1].irq_en);

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = 16'h0000;
      case (reg_addr)
         dpgpio_pkg::G1_MODE: rdata_d = {8'h00, mode_q};
         dpgpio_pkg::G1_FUNC: rdata_d = func_q;
         dpgpio_pkg::G2_MODE: rdata_d = dpgpio_pkg::G2_MODE_VAL;
         dpgpio_pkg::G2_FUNC: rdata_d = dpgpio_pkg::G2_FUNC_VAL;
         default: begin
            if (reg_addr[1:0] == 2'b00 && reg_addr[4:2] < 3'h6) begin
               rdata_d = ctl_rd[reg_addr[5]][reg_addr[4:2]];
            end
         end
      endcase
   end

   // Read data one cycle after the strobe, only then
   always_ff @(posedge sys_clk) begin
      if (srst) rdata_q <= 16'h0000;
      else if (reg_rd) rdata_q <= rdata_d;
      else rdata_q <= 16'h0000;
   end
   assign reg_rdata = rdata_q;
endmodule : dpgpio_top

// >>> sim/dpgpio_far.sv
// Far side model: pin levels and universal router drive
`timescale 1ns/100ps
module dpgpio_far (
   input logic sys_clk,
   input logic [7:0] lvl1,
   input logic [7:0] lvl2,
   output logic [7:0] first_group_pin_in = 8'h00,
   output logic [7:0] second_group_pin_in = 8'h00,
   output logic [7:0] router_out = 8'h5a,
   output logic [7:0] router_oe = 8'h0f
);
   // Router lines toggle every cycle so stale data never looks right
   always_ff @(posedge sys_clk) begin
      first_group_pin_in <= lvl1;
      second_group_pin_in <= lvl2;
      router_out <= ~router_out;
      router_oe <= ~router_oe;
   end
endmodule : dpgpio_far

// >>> sim/dpgpio_checker.sv
// Checker of read data, pin routing and the interrupt line
`timescale 1ns/100ps
module dpgpio_checker #(
   parameter int DEB_CYC = 4
) (
   input logic sys_clk,
   input logic srst,
   input logic [5:0] reg_addr,
   input logic reg_wr,
   input logic reg_rd,
   input logic [15:0] reg_rdata,
   input dpgpio_pkg::dpgpio_pad_s first_group_pad,
   input logic [7:0] first_group_periph_sel,
   input logic [7:0] router_pin_sel,
   input logic [7:0] router_out,
   input logic timer0_ext_clock_b,
   input logic timer1_ext_clock_b,
   input logic timer2_ext_clock_a,
   input logic timer2_ext_clock_b,
   input logic irq
);
   // Pins given to a peripheral other than the router
   logic [7:0] own;
   logic [3:0] tmr;
   assign own = first_group_periph_sel & ~router_pin_sel;
   assign tmr = {timer2_ext_clock_b, timer2_ext_clock_a,
      timer1_ext_clock_b, timer0_ext_clock_b};
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   property p_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
   a_idle: assert property (p_idle)
      else $error("read data not idle");
   property p_func; reg_rd && reg_addr == 6'h3c |=> reg_rdata == 16'haaaa;
   endproperty
   a_func: assert property (p_func)
      else $error("fixed selector wrong");
   property p_flag; reg_rd && reg_addr[4:0] == 5'h0c |=> !reg_rdata[15:8];
   endproperty
   a_flag: assert property (p_flag)
      else $error("flag upper byte set");
   property p_rsub; (router_pin_sel & ~first_group_periph_sel) == 8'h00;
   endproperty
   a_rsub: assert property (p_rsub)
      else $error("router pin not in mode");
   property p_rdrv; ((first_group_pad.out ^ router_out) & router_pin_sel) == 0;
   endproperty
   a_rdrv: assert property (p_rdrv)
      else $error("router drive lost");
   property p_own; (first_group_pad.oe & own) == 8'h00; endproperty
   a_own: assert property (p_own)
      else $error("peripheral pin driven");
   property p_tmr; (tmr & ~own[3:0]) == 4'h0; endproperty
   a_tmr: assert property (p_tmr)
      else $error("timer clock leaks");
   property p_fall; $fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2);
   endproperty
   a_fall: assert property (p_fall)
      else $error("irq fell without write");
endmodule : dpgpio_checker
bind dpgpio_top dpgpio_checker #(.DEB_CYC(DEB_CYC)) chk_u (
   .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
   .first_group_pad(first_group_pad),
   .first_group_periph_sel(first_group_periph_sel),
   .router_pin_sel(router_pin_sel), .router_out(router_out),
   .timer0_ext_clock_b(timer0_ext_clock_b),
   .timer1_ext_clock_b(timer1_ext_clock_b),
   .timer2_ext_clock_a(timer2_ext_clock_a),
   .timer2_ext_clock_b(timer2_ext_clock_b));

// >>> sim/dual_port_group_gpio_tb.sv
// Self-checking bench for the dual port group GPIO block
`timescale 1ns/100ps
module dual_port_group_gpio_tb;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic irq;
   logic [7:0] lvl1 = 8'h00;
   logic [7:0] lvl2 = 8'h00;
   logic [7:0] pin1, pin2, r_out, r_oe, psel, rsel;
   logic [3:0] tmr;
   dpgpio_pkg::dpgpio_pad_s pad1, pad2;
   int miscompares = 0;
   int samples_checked = 0;
   // Readback of every slot after writing 16'h5a3c to all of them
   logic [15:0] ex [16] = '{16'h5a00, 16'h5a3c, 16'h5a3c, 16'h0000,
      16'h5a3c, 16'h003c, 16'h003c, 16'h5a3c, 16'h5a00, 16'h5a3c,
      16'h5a3c, 16'h0000, 16'h5a3c, 16'h003c, 16'h0000, 16'haaaa};
   always #20 sys_clk = ~sys_clk;
   dpgpio_top #(.DEB_CYC(4)) dut_u (.sys_clk(sys_clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_group_pin_in(pin1),
      .second_group_pin_in(pin2), .first_group_pad(pad1),
      .second_group_pad(pad2), .first_group_periph_sel(psel),
      .router_pin_sel(rsel), .router_out(r_out), .router_oe(r_oe),
      .timer0_ext_clock_b(tmr[0]), .timer1_ext_clock_b(tmr[1]),
      .timer2_ext_clock_a(tmr[2]), .timer2_ext_clock_b(tmr[3]), .irq(irq));
   dpgpio_far far_u (.sys_clk(sys_clk), .lvl1(lvl1), .lvl2(lvl2),
      .first_group_pin_in(pin1), .second_group_pin_in(pin2),
      .router_out(r_out), .router_oe(r_oe));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One strobe cycle; read data is looked at in the cycle after it
   task acc(input logic w, input logic [5:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= w;
      reg_rd <= ~w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
   endtask : acc
   task rd(input logic [5:0] a, input logic [15:0] e);
      acc(1'b0, a, 16'h0000);
      chk(reg_rdata, e);
   endtask : rd
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task do_reset;
      srst <= 1'b1;
      tick(10);
      srst <= 1'b0;
   endtask : do_reset
   task give_verdict;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   // Main sequence: reset values, access kinds, interrupts, routing
   initial begin
      do_reset();
      for (int i = 0; i < 16; i++) rd(6'(i * 4), ex[15] & {16{i == 15}});
      for (int i = 0; i < 16; i++) acc(1'b1, 6'(i * 4), 16'h5a3c);
      for (int i = 0; i < 16; i++) rd(6'(i * 4), ex[i]);
      rd(6'h02, 16'h0000);
      chk({pad2.ie, pad2.oe}, 16'h5a3c);
      chk({pad1.pull_up, pad1.pull_en}, 16'h5a3c);
      chk({pad2.out, pad2.pull_up}, 16'h5a5a);
      chk({pad2.pull_en, pad1.ie}, 16'h3c5a);
      do_reset();
      acc(1'b1, 6'h04, 16'hff00);
      acc(1'b1, 6'h24, 16'hff00);
      acc(1'b1, 6'h10, 16'h0201);
      lvl1 <= 8'h03;
      lvl2 <= 8'h80;
      tick(6);
      rd(6'h0c, 16'h0001);
      rd(6'h2c, 16'h0080);
      lvl1 <= 8'h01;
      tick(6);
      rd(6'h0c, 16'h0003);
      acc(1'b1, 6'h0c, 16'h0002);
      rd(6'h0c, 16'h0001);
      chk(irq, 16'h0001);
      acc(1'b1, 6'h0c, 16'hff01);
      rd(6'h0c, 16'h0000);
      chk(irq, 16'h0000);
      acc(1'b1, 6'h30, 16'h0080);
      chk(irq, 16'h0001);
      acc(1'b1, 6'h2c, 16'h0080);
      chk(irq, 16'h0000);
      acc(1'b1, 6'h14, 16'h0004);
      lvl1 <= 8'h05;
      tick(2);
      lvl1 <= 8'h01;
      tick(10);
      rd(6'h0c, 16'h0000);
      lvl1 <= 8'h05;
      tick(12);
      rd(6'h0c, 16'h0004);
      acc(1'b1, 6'h18, 16'h00ff);
      acc(1'b1, 6'h1c, 16'h7900);
      chk({psel, rsel}, 16'hff90);
      lvl1 <= 8'h0a;
      tick(3);
      chk(tmr, 16'h000a);
      acc(1'b1, 6'h18, 16'h0000);
      chk({psel, rsel}, 16'h0000);
      chk({12'h000, tmr}, 16'h0000);
      give_verdict();
   end
   // Hang guard, far beyond the roughly 200 cycles the tests take
   initial begin
      repeat (3000) @(posedge sys_clk);
      miscompares++;
      give_verdict();
   end
endmodule : dual_port_group_gpio_tb
